// file: hw/fmsr_pkg.sv
// fmsr_pkg: command codes, field positions, reset values and carrier types
// for the fault-mask and status command bank.
// assumes: a pmbus protocol engine upstream decodes frames into single-byte commands.
package fmsr_pkg;

    // command codes of the bank
    localparam logic [7:0] CMD_FAULT_MASK  = 8'hfa;
    localparam logic [7:0] CMD_GEN_STATUS  = 8'hfb;
    localparam logic [7:0] CMD_PHASE_STAT  = 8'hfc;

    // reset values
    localparam logic [7:0] FAULT_MASK_RST  = 8'h00;
    localparam logic [7:0] RD_DATA_RST     = 8'h00;

    // fault_source_mask fields
    localparam int MB_OUTPUT_VOLTAGE = 7;
    localparam int MB_OUTPUT_CURRENT = 6;
    localparam int MB_COMM_MEM_LOGIC = 3;
    localparam int MB_MON_VOLTAGE    = 2;
    localparam int MB_OUTPUT_POWER   = 0;
    // bits that hold storage; bits 5, 4 and 1 are reserved and read zero
    localparam logic [7:0] MASK_WR_BITS = 8'hcd;

    // general_status fields
    localparam int GS_FAULT       = 7;
    localparam int GS_ALERT       = 6;
    localparam int GS_POWER_GOOD  = 5;
    localparam int GS_READY       = 4;

    // phase_activity_status fields
    localparam int PS_PHASE4      = 5;
    localparam int PS_PHASE3      = 4;
    localparam int PS_PHASE2      = 3;
    localparam int PS_POWER_SAVE  = 2;

    // status word bit that carries power-good now
    localparam int SW_POWER_GOOD  = 3;

    // number of fault sources routed through the mask
    localparam int NUM_SRC        = 5;

    // one command from the protocol engine
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] code;
        logic [7:0] data;
    } fmsr_cmd_t;

    // any-bit-set summaries of each status register feeding the mask
    typedef struct packed {
        logic output_voltage;
        logic output_current;
        logic comm_memory_logic_status;
        logic monitored_voltage_input;
        logic output_power;
    } fmsr_src_t;

    // whole state of the bank
    typedef struct packed {
        logic [7:0] mask;
        logic [7:0] rd_data;
        logic       rd_valid;
        logic       cmd_unknown;
        logic       fault;
        logic       mon_alert;
        logic [7:0] status_word_lo;
    } fmsr_state_t;

endpackage

// file: hw/fmsr_src_gate.sv
// fmsr_src_gate: blocks each raw fault source whose mask bit is set.
// assumes: raw and mask vectors are aligned bit for bit by the caller.
`timescale 1ns/1ns
module fmsr_src_gate #(
    parameter int W = 1
) (
    input  wire logic [W-1:0] raw,
    input  wire logic [W-1:0] block,
    output logic      [W-1:0] pass
);
    // refuse an empty gate
    if (W < 1) begin : g_bad_width
        $error("fmsr_src_gate: W must be at least 1");
    end

    // a set block bit hides its source entirely
    assign pass = raw & ~block;
endmodule // fmsr_src_gate

// file: hw/fmsr_bank.sv
// fmsr_bank: fault-mask byte plus read-only general and phase status bytes,
// reached by pmbus command code; gates four fault sources onto one fault line and the voltage monitor onto mon_alert_r.
// assumes: a protocol engine delivers one-cycle command strobes synchronous to core_clk.
//
// Functional notes
// RL1 - mask bit 7 blocks output-voltage faults
// RL2 - mask at 0xfa, read/write, resets zero
// RL3 - mask bit 6 blocks output-current faults
// RL4 - mask bit 3 blocks comm/memory/logic faults
// RL5 - mask bit 2 blocks monitored-voltage limit alert
// RL6 - mask bit 0 blocks output-power faults
// RL7 - power-good moved to status word bit 3
// RL8 - phase bits 5..3 show phases 4..2 enabled
// RL9 - phase bit 2 shows power-save asserted
// RL10 - status writes ignored; reserved mask bits zero
`timescale 1ns/1ns
module fmsr_bank (
    input  wire logic              core_clk,
    input  wire logic              rst_b,
    input  wire fmsr_pkg::fmsr_cmd_t cmd,
    input  wire fmsr_pkg::fmsr_src_t src,
    input  wire logic              alert_in,
    input  wire logic              ready_in,
    input  wire logic              power_good,
    input  wire logic [2:0]        phase_en,
    input  wire logic              power_save_indicator,
    output logic [7:0]             rd_data_r,
    output logic                   rd_valid_r,
    output logic                   cmd_unknown_r,
    output logic [7:0]             mask_r,
    output logic                   fault_r,
    output logic                   mon_alert_r,
    output logic [7:0]             status_word_lo_r
);
    fmsr_pkg::fmsr_state_t st_r;
    fmsr_pkg::fmsr_state_t st_nxt;
    logic [fmsr_pkg::NUM_SRC-1:0] src_raw;
    logic [fmsr_pkg::NUM_SRC-1:0] src_block;
    logic [fmsr_pkg::NUM_SRC-1:0] src_pass;
    logic [7:0]                   gen_status;
    logic [7:0]                   phase_status;

    // sources in struct order: voltage, current, comm/logic, monitor, power
    assign src_raw = {src.output_voltage, src.output_current, src.comm_memory_logic_status,
                      src.monitored_voltage_input, src.output_power};
    assign src_block = {st_r.mask[fmsr_pkg::MB_OUTPUT_VOLTAGE],   // [RL1]
                        st_r.mask[fmsr_pkg::MB_OUTPUT_CURRENT],   // [RL3]
                        st_r.mask[fmsr_pkg::MB_COMM_MEM_LOGIC],   // [RL4]
                        st_r.mask[fmsr_pkg::MB_MON_VOLTAGE],      // [RL5]
                        st_r.mask[fmsr_pkg::MB_OUTPUT_POWER]};    // [RL6]

    fmsr_src_gate #(
        .W (fmsr_pkg::NUM_SRC)
    ) u_gate (
        .raw   (src_raw),
        .block (src_block),
        .pass  (src_pass)
    );

    // general status byte; power-good bit held at zero, it lives in the status word now
    always_comb begin
        gen_status = 8'h00;
        gen_status[fmsr_pkg::GS_FAULT]      = st_r.fault;
        gen_status[fmsr_pkg::GS_ALERT]      = alert_in;
        gen_status[fmsr_pkg::GS_POWER_GOOD] = 1'b0;      // [RL7]
        gen_status[fmsr_pkg::GS_READY]      = ready_in;
    end

    // phase status byte straight from live inputs, so it has no storage to corrupt
    always_comb begin
        phase_status = 8'h00;
        phase_status[fmsr_pkg::PS_PHASE4]     = phase_en[2];          // [RL8]
        phase_status[fmsr_pkg::PS_PHASE3]     = phase_en[1];          // [RL8]
        phase_status[fmsr_pkg::PS_PHASE2]     = phase_en[0];          // [RL8]
        phase_status[fmsr_pkg::PS_POWER_SAVE] = power_save_indicator; // [RL9]
    end

    // next state: command decode, fault gating, status word
    always_comb begin
        st_nxt             = st_r;
        st_nxt.rd_valid    = 1'b0;
        st_nxt.cmd_unknown = 1'b0;
        // the voltage monitor raises an alert, not a fault, so it stays off the fault line
        st_nxt.fault       = src_pass[4] | src_pass[3] | src_pass[2] | src_pass[0]; // [RL1] [RL3] [RL4] [RL6]
        st_nxt.mon_alert   = src_pass[1];                                          // [RL5]
        st_nxt.status_word_lo = 8'h00;
        st_nxt.status_word_lo[fmsr_pkg::SW_POWER_GOOD] = power_good;              // [RL7]
        if (cmd.valid) begin
            unique case (cmd.code)
                fmsr_pkg::CMD_FAULT_MASK: begin
                    if (cmd.write) begin
                        st_nxt.mask = cmd.data & fmsr_pkg::MASK_WR_BITS; // [RL2] [RL10]
                    end else begin
                        st_nxt.rd_data  = st_r.mask;                     // [RL2]
                        st_nxt.rd_valid = 1'b1;
                    end
                end
                fmsr_pkg::CMD_GEN_STATUS: begin
                    // a write is dropped silently: nothing here is storage
                    if (!cmd.write) begin                                // [RL10]
                        st_nxt.rd_data  = gen_status;
                        st_nxt.rd_valid = 1'b1;
                    end
                end
                fmsr_pkg::CMD_PHASE_STAT: begin
                    if (!cmd.write) begin                                // [RL10]
                        st_nxt.rd_data  = phase_status;
                        st_nxt.rd_valid = 1'b1;
                    end
                end
                default: begin
                    // not ours: flag it so the engine can nack the frame
                    st_nxt.cmd_unknown = 1'b1;
                    if (!cmd.write) begin
                        st_nxt.rd_data  = fmsr_pkg::RD_DATA_RST;
                        st_nxt.rd_valid = 1'b1;
                    end
                end
            endcase
        end
    end

    // state register; mask comes up clear so nothing is hidden after reset
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r                <= '0;
            st_r.mask           <= fmsr_pkg::FAULT_MASK_RST; // [RL2]
            st_r.rd_data        <= fmsr_pkg::RD_DATA_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rd_data_r        = st_r.rd_data;
    assign rd_valid_r       = st_r.rd_valid;
    assign cmd_unknown_r    = st_r.cmd_unknown;
    assign mask_r           = st_r.mask;
    assign fault_r          = st_r.fault;
    assign mon_alert_r      = st_r.mon_alert;
    assign status_word_lo_r = st_r.status_word_lo;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    sequence s_read(logic [7:0] c);
        cmd.valid && !cmd.write && cmd.code == c;
    endsequence

    sequence s_write(logic [7:0] c);
        cmd.valid && cmd.write && cmd.code == c;
    endsequence

    a_volt_mask_block: assert property ( // [RL1]
        (st_r.mask[7] && src_raw == 5'h10) |=> !fault_r)
        else $error("masked output-voltage fault reached the fault line");

    a_mask_write_read: assert property ( // [RL2]
        s_write(8'hfa) ##1 s_read(8'hfa) |=> rd_valid_r && rd_data_r == ($past(cmd.data, 2) & 8'hcd))
        else $error("fault mask did not read back what was written");

    a_curr_mask_block: assert property ( // [RL3]
        (st_r.mask[6] && src_raw == 5'h08) |=> !fault_r)
        else $error("masked output-current fault reached the fault line");

    a_comm_mask_block: assert property ( // [RL4]
        (st_r.mask[3] && src_raw == 5'h04) |=> !fault_r)
        else $error("masked comm/memory/logic fault reached the fault line");

    a_monitor_alert_gate: assert property ( // [RL5]
        src.monitored_voltage_input |=> mon_alert_r == !$past(st_r.mask[2]))
        else $error("monitored voltage alert not gated by mask bit 2");

    a_power_mask_block: assert property ( // [RL6]
        (st_r.mask[0] && src_raw == 5'h01) |=> !fault_r)
        else $error("masked output-power fault reached the fault line");

    a_unmasked_fault: assert property ( // [RL1]
        (src.output_voltage && !st_r.mask[7]) |=> fault_r)
        else $error("unmasked output-voltage fault not raised");

    a_pg_relocated: assert property ( // [RL7]
        s_read(8'hfb) |=> !rd_data_r[5] && status_word_lo_r[3] == $past(power_good))
        else $error("power-good not carried in status word bit 3");

    a_phase_bits: assert property ( // [RL8]
        s_read(8'hfc) |=> rd_data_r[5:3] == $past(phase_en) && rd_data_r[1:0] == 2'b00)
        else $error("phase status does not follow phase enables");

    a_save_bit: assert property ( // [RL9]
        s_read(8'hfc) |=> rd_data_r[2] == $past(power_save_indicator))
        else $error("power-save bit does not follow its input");

    a_ro_write_inert: assert property ( // [RL10]
        (cmd.valid && cmd.write && cmd.code != 8'hfa) |=> $stable(mask_r) && !rd_valid_r)
        else $error("write to a read-only code disturbed the bank");

    a_reserved_zero: assert property ( // [RL10]
        (mask_r & 8'h32) == 8'h00)
        else $error("reserved fault mask bits read nonzero");
endmodule // fmsr_bank

// file: verif/fmsr_host_model.sv
// fmsr_host_model: host side of the command port, one byte per command.
// assumes: the bank takes cmd on the rising edge and registers its answer on that same edge.
`timescale 1ns/1ns
module fmsr_host_model (
    input  wire logic          core_clk,
    output fmsr_pkg::fmsr_cmd_t cmd,
    input  wire logic [7:0]    rd_data_r,
    input  wire logic          rd_valid_r,
    input  wire logic          cmd_unknown_r
);
    // idle command port at time zero
    initial cmd = '{valid: 1'b0, write: 1'b0, code: 8'h00, data: 8'h00};

    // one strobe, then the answer is picked up a cycle later, once settled
    task automatic xfer(input logic wr, input logic [7:0] code, input logic [7:0] data,
                        output logic [7:0] rdat, output logic rv, output logic unk);
        @(negedge core_clk);
        cmd.valid = 1'b1;
        cmd.write = wr;
        cmd.code  = code; // single-byte command
        cmd.data  = data;
        @(negedge core_clk);
        rdat = rd_data_r;
        rv   = rd_valid_r;
        unk  = cmd_unknown_r;
        // released fields flip so a stale byte is never mistaken for a live one
        cmd.valid = 1'b0;
        cmd.code  = ~code;
        cmd.data  = ~data;
    endtask

    // write then read of one code on consecutive edges; valid stays up between them
    task automatic wr_rd(input logic [7:0] code, input logic [7:0] data,
                         output logic [7:0] rdat, output logic rv);
        @(negedge core_clk);
        cmd.valid = 1'b1;
        cmd.write = 1'b1;
        cmd.code  = code;
        cmd.data  = data;
        @(negedge core_clk);
        cmd.write = 1'b0; // read taken on the very next edge
        @(negedge core_clk);
        rdat = rd_data_r;
        rv   = rd_valid_r;
        cmd.valid = 1'b0;
        cmd.code  = ~code;
        cmd.data  = ~data;
    endtask
endmodule // fmsr_host_model

// file: verif/test_fmsr_bank.sv
// test_fmsr_bank: directed checks of the mask byte, fault gating and status bytes.
// assumes: fmsr_pkg, fmsr_bank and fmsr_host_model are compiled before this file.
`timescale 1ns/1ns
module test_fmsr_bank;
    logic                core_clk   = 1'b0;
    logic                rst_b      = 1'b0;
    fmsr_pkg::fmsr_cmd_t cmd;
    fmsr_pkg::fmsr_src_t src        = '0;
    logic                alert_in   = 1'b0;
    logic                ready_in   = 1'b0;
    logic                power_good = 1'b0;
    logic [2:0]          phase_en   = 3'h0;
    logic                power_save_indicator = 1'b0;
    logic [7:0]          rd_data_r, mask_r, status_word_lo_r, rd;
    logic                rd_valid_r, cmd_unknown_r, fault_r, mon_alert_r, rv, unk;
    int                  n_mismatch = 0;
    int                  n_checks   = 0;
    int                  cycles     = 0;
    // mask bit for each source, in the source struct's order (msb first)
    logic [7:0]          mbit [5]   = '{8'h80, 8'h40, 8'h08, 8'h04, 8'h01};

    fmsr_bank i_dut (.core_clk(core_clk), .rst_b(rst_b), .cmd(cmd), .src(src), .alert_in(alert_in),
        .ready_in(ready_in), .power_good(power_good), .phase_en(phase_en),
        .power_save_indicator(power_save_indicator), .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r),
        .cmd_unknown_r(cmd_unknown_r), .mask_r(mask_r), .fault_r(fault_r), .mon_alert_r(mon_alert_r),
        .status_word_lo_r(status_word_lo_r));
    fmsr_host_model i_host (.core_clk(core_clk), .cmd(cmd), .rd_data_r(rd_data_r),
        .rd_valid_r(rd_valid_r), .cmd_unknown_r(cmd_unknown_r));

    // 50 ns period
    initial forever #25 core_clk = ~core_clk;

    // hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 4000) begin
            n_mismatch++;
            close_out();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] code, input logic [7:0] data);
        i_host.xfer(1'b1, code, data, rd, rv, unk);
    endtask

    task automatic rdc(input logic [7:0] code);
        i_host.xfer(1'b0, code, 8'h00, rd, rv, unk);
    endtask

    task automatic close_out();
        $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (16) @(negedge core_clk);
        rst_b = 1'b1;
        chk(mask_r, 8'h00);
        rdc(8'hfa);
        chk(rd, 8'h00);
        chk({6'h00, rv, unk}, 8'h02);
        wr(8'hfa, 8'hff);
        chk(mask_r, 8'hcd);
        rdc(8'hfa);
        chk(rd, 8'hcd);
        // back-to-back write and read: the read must already see the new byte
        i_host.wr_rd(8'hfa, 8'h5a, rd, rv);
        chk(rd, 8'h48);
        chk({7'h00, rv}, 8'h01);
        // each source alone: passes when unmasked, blocked once its bit is set
        for (int i = 0; i < 5; i++) begin
            wr(8'hfa, 8'h00);
            src = fmsr_pkg::fmsr_src_t'(5'h10 >> i);
            repeat (2) @(negedge core_clk);
            chk({6'h00, fault_r, mon_alert_r}, (i == 3) ? 8'h01 : 8'h02);
            wr(8'hfa, mbit[i]);
            @(negedge core_clk);
            chk({6'h00, fault_r, mon_alert_r}, 8'h00);
        end
        // every phase pattern with power-save off and on
        for (int k = 0; k < 16; k++) begin
            phase_en = k[3:1];
            power_save_indicator = k[0];
            rdc(8'hfc);
            chk(rd, {2'b00, k[3:1], k[0], 2'b00});
        end
        // general status with fault, alert and ready high; power-good driven high shows only in the status word
        wr(8'hfa, 8'h00);
        src = fmsr_pkg::fmsr_src_t'(5'h01);
        alert_in = 1'b1;
        ready_in = 1'b1;
        power_good = 1'b1;
        rdc(8'hfb);
        chk(rd, 8'hd0);
        chk(status_word_lo_r, 8'h08);
        // writes to the read-only bytes change nothing and raise no flag
        wr(8'hfb, 8'h2f);
        chk({7'h00, unk}, 8'h00);
        wr(8'hfc, 8'hc3);
        chk({6'h00, rv, unk}, 8'h00);
        rdc(8'hfb);
        chk(rd, 8'hd0);
        rdc(8'hfc);
        chk(rd, 8'h3c);
        // code outside the bank
        rdc(8'h55);
        chk({rd[5:0], rv, unk}, 8'h03);
        power_good = 1'b0;
        repeat (2) @(negedge core_clk);
        chk(status_word_lo_r, 8'h00);
        // second reset mid-run clears the mask again
        wr(8'hfa, 8'hcd);
        rst_b = 1'b0;
        @(negedge core_clk);
        chk(mask_r, 8'h00);
        rst_b = 1'b1;
        rdc(8'hfa);
        chk(rd, 8'h00);
        close_out();
    end
endmodule // test_fmsr_bank
